// File: rtl/fsmc_sync.sv
module fsmc_sync
  import fsmc_pkg::*;
#(
  parameter int unsigned W = PINS_W,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  // =====================================================
  // two-stage synchroniser; stage one feeds stage two only
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb begin
    s1_nxt = d_in;
    s2_nxt = s1_r;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s1_r <= INIT;
      q_out <= INIT;
    end else begin
      s1_r <= s1_nxt;
      q_out <= s2_nxt;
    end
  end

endmodule // fsmc_sync

// File: rtl/fsmc_timer.sv
module fsmc_timer
  import fsmc_pkg::*;
#(
  parameter int unsigned W = TMR_W
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [W-1:0] val_in,
  output logic expire_out
);

  // =====================================================
  // down counter; loading zero stops it
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic expire_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    expire_nxt = 1'b0;
    if (load_in) begin
      cnt_nxt = val_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
      expire_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_r <= '0;
      expire_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      expire_out <= expire_nxt;
    end
  end

endmodule // fsmc_timer

// File: rtl/fsmc_top.sv
// What this block does
// - power-up enters start-up mode
// - any system reset returns to start-up
// - latch readable code of last reset cause
// - bus or local wake leaves low-power modes
// - hold host reset low for lengthened time
// - reset length from select bit else default
// - watchdog init decides normal/flash or restart
// - restart mode forces long reset length
// - success from restart goes only to normal
// - restart failure or no supply: fail-safe
// - severe faults send any mode to fail-safe
// - leave fail-safe on wake with good oscillator
// - fail-safe exit: delay, supply on, long reset
// - normal mode grants transceivers, inhibit, enable
// - bad watchdog service in normal resets
// - unanswered interrupt in normal resets
// - can stays off until medium control set
// - inhibit output floats until driven
// - cyclic battery output tracks wake sampling
module fsmc_top
  import fsmc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire fsmc_pins_type pins_in,
  input wire fsmc_host_type host_in,
  output logic host_reset_out_n,
  output logic [3:0] reset_source_out,
  output logic [2:0] mode_out,
  output fsmc_grant_type grant_out,
  output logic mcu_supply_regulator_out,
  output logic switched_battery_output_out,
  output logic wake_sample_out,
  output logic inhibit_limp_output_out,
  output logic inhibit_limp_output_oe_n_out
);

  // =====================================================
  // synchronised pins
  fsmc_pins_type pins_s;
  logic [PINS_W-1:0] pins_q;

  fsmc_sync #(
    .W(PINS_W),
    .INIT(PINS_RESET)
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(pins_in),
    .q_out(pins_q)
  );

  assign pins_s = fsmc_pins_type'(pins_q);

  // =====================================================
  // cyclic wake sampling
  logic [TMR_W-1:0] cyc_cnt_r;
  logic [TMR_W-1:0] cyc_cnt_nxt;
  logic v3_r;
  logic v3_nxt;
  logic sample_r;
  logic sample_nxt;
  logic low_power;

  always_comb begin
    cyc_cnt_nxt = (cyc_cnt_r == '0) ? CYC_PERIOD_CYC - TMR_W'(1) : cyc_cnt_r - TMR_W'(1);
    // output is on during the last slice of the period, wake sampled at its end
    if (host_in.wake_cyclic) begin
      v3_nxt = (cyc_cnt_nxt < CYC_ON_CYC);
      sample_nxt = (cyc_cnt_nxt == '0);
    end else begin
      v3_nxt = host_in.v3_on;
      sample_nxt = 1'b1;
    end
    if (low_power) begin
      v3_nxt = v3_nxt & host_in.v3_on | v3_nxt & host_in.wake_cyclic;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cyc_cnt_r <= '0;
      v3_r <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      cyc_cnt_r <= cyc_cnt_nxt;
      v3_r <= v3_nxt;
      sample_r <= sample_nxt;
    end
  end

  // =====================================================
  // wake and fault decode
  logic wake_any;
  logic fault_now;

  always_comb begin
    wake_any = pins_s.wake_can | pins_s.wake_lin | (pins_s.wake_local & sample_r);
    // a stopped oscillator counts as a severe fault
    fault_now = pins_s.severe_fault | ~pins_s.osc_ok;
  end

  // =====================================================
  // timers
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_exp;
  logic int_load;
  logic [TMR_W-1:0] int_val;
  logic int_exp;

  fsmc_timer #(
    .W(TMR_W)
  ) u_mode_tmr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .load_in(tmr_load),
    .val_in(tmr_val),
    .expire_out(tmr_exp)
  );

  fsmc_timer #(
    .W(TMR_W)
  ) u_int_tmr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .load_in(int_load),
    .val_in(int_val),
    .expire_out(int_exp)
  );

  // =====================================================
  // mode state machine
  fsmc_state_type state_r;
  fsmc_state_type state_nxt;
  logic [3:0] rsrc_r;
  logic [3:0] rsrc_nxt;
  logic force_long_r;
  logic force_long_nxt;
  logic flash_armed_r;
  logic flash_armed_nxt;
  logic sys_reset;
  logic [3:0] sys_src;
  logic boot_r;

  function automatic logic [TMR_W-1:0] rst_len(input logic force_long, input logic sel);
    rst_len = (force_long | sel) ? RST_LONG_CYC : RST_SHORT_CYC;
  endfunction

  always_comb begin
    state_nxt = state_r;
    rsrc_nxt = rsrc_r;
    force_long_nxt = force_long_r;
    flash_armed_nxt = flash_armed_r;
    sys_reset = 1'b0;
    sys_src = rsrc_r;
    tmr_load = 1'b0;
    tmr_val = TMR_IDLE;
    case (state_r)
      ST_STARTUP_RST: begin
        if (tmr_exp) begin
          state_nxt = ST_STARTUP_WAIT;
        end
      end
      ST_STARTUP_WAIT: begin
        if (host_in.wd_init_ok) begin
          // flash only after a completed entry sequence
          if (host_in.flash_select && flash_armed_r) begin
            state_nxt = ST_FLASH;
          end else begin
            state_nxt = ST_NORMAL;
          end
          flash_armed_nxt = 1'b0;
        end else if (tmr_exp) begin
          state_nxt = ST_RESTART_RST;
          rsrc_nxt = RS_WD_INIT;
        end
      end
      ST_RESTART_RST: begin
        if (!pins_s.v1_ok && tmr_exp) begin
          state_nxt = ST_FAILSAFE;
        end else if (tmr_exp) begin
          state_nxt = ST_RESTART_WAIT;
        end
      end
      ST_RESTART_WAIT: begin
        if (!pins_s.v1_ok) begin
          state_nxt = ST_FAILSAFE;
        end else if (host_in.wd_init_ok) begin
          state_nxt = ST_NORMAL;
          flash_armed_nxt = 1'b0;
        end else if (tmr_exp) begin
          state_nxt = ST_FAILSAFE;
        end
      end
      ST_NORMAL: begin
        if (host_in.wd_service_err) begin
          sys_reset = 1'b1;
          sys_src = RS_WD_SERVICE;
        end else if (int_exp) begin
          sys_reset = 1'b1;
          sys_src = RS_INT_TIMEOUT;
        end else if (host_in.soft_reset) begin
          sys_reset = 1'b1;
          sys_src = RS_SOFT;
        end else if (host_in.flash_entry) begin
          sys_reset = 1'b1;
          sys_src = RS_FLASH_ENTRY;
          flash_armed_nxt = 1'b1;
        end else if (host_in.sleep_req) begin
          state_nxt = ST_SLEEP;
        end else if (host_in.standby_req) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_FLASH: begin
        if (host_in.wd_service_err) begin
          sys_reset = 1'b1;
          sys_src = RS_WD_SERVICE;
        end else if (host_in.flash_exit) begin
          sys_reset = 1'b1;
          sys_src = RS_FLASH_EXIT;
        end
      end
      ST_STANDBY: begin
        if (wake_any) begin
          sys_reset = 1'b1;
          sys_src = RS_WAKE;
        end else if (host_in.wd_service_err) begin
          sys_reset = 1'b1;
          sys_src = RS_WD_SERVICE;
        end else if (int_exp) begin
          sys_reset = 1'b1;
          sys_src = RS_INT_TIMEOUT;
        end else if (host_in.normal_req) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          sys_reset = 1'b1;
          sys_src = RS_WAKE;
        end else if (host_in.wd_service_err) begin
          sys_reset = 1'b1;
          sys_src = RS_WD_SERVICE;
        end
      end
      ST_FAILSAFE: begin
        if (wake_any && pins_s.osc_ok) begin
          state_nxt = ST_FS_DELAY;
        end
      end
      ST_FS_DELAY: begin
        // supply stays off so it is fully discharged before restart
        if (tmr_exp) begin
          state_nxt = ST_STARTUP_RST;
          rsrc_nxt = RS_FAILSAFE_EXIT;
          force_long_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_STARTUP_RST;
      end
    endcase
    if (sys_reset) begin
      state_nxt = ST_STARTUP_RST;
      rsrc_nxt = sys_src;
    end
    if (fault_now && state_r != ST_FAILSAFE) begin
      state_nxt = ST_FAILSAFE;
    end
    if (state_nxt == ST_RESTART_RST) begin
      force_long_nxt = 1'b1;
    end else if (state_nxt == ST_NORMAL) begin
      force_long_nxt = 1'b0;
    end
    // start the mode timer on each entry, on start-up re-entry and after power-on reset
    if (state_nxt != state_r || sys_reset || boot_r) begin
      case (state_nxt)
        ST_STARTUP_RST, ST_RESTART_RST: begin
          tmr_load = 1'b1;
          tmr_val = rst_len(force_long_nxt, host_in.reset_length_select);
        end
        ST_STARTUP_WAIT, ST_RESTART_WAIT: begin
          tmr_load = 1'b1;
          tmr_val = WD_INIT_CYC;
        end
        ST_FS_DELAY: begin
          tmr_load = 1'b1;
          tmr_val = RET_CYC;
        end
        default: begin
          tmr_load = 1'b1;
          tmr_val = TMR_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    low_power = (state_r == ST_FAILSAFE) || (state_r == ST_FS_DELAY);
    // interrupt response watch only in normal and standby modes
    int_load = 1'b0;
    int_val = TMR_IDLE;
    if (state_r != ST_NORMAL && state_r != ST_STANDBY) begin
      int_load = 1'b1;
    end else if (host_in.int_ack) begin
      int_load = 1'b1;
    end else if (host_in.int_raise) begin
      int_load = 1'b1;
      int_val = INT_RESP_CYC;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_r <= ST_STARTUP_RST;
      boot_r <= 1'b1;
      rsrc_r <= RS_POWER_ON;
      force_long_r <= 1'b0;
      flash_armed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      boot_r <= 1'b0;
      rsrc_r <= rsrc_nxt;
      force_long_r <= force_long_nxt;
      flash_armed_r <= flash_armed_nxt;
    end
  end

  // =====================================================
  // outputs
  logic cmc_prev_r;
  logic can_on_r;
  logic can_on_nxt;
  logic rst_n_nxt;
  logic [2:0] mode_nxt;
  fsmc_grant_type grant_nxt;
  logic v1_nxt;
  logic inh_oe_n_nxt;

  always_comb begin
    // medium control must be raised after entry, a stale high does not count
    can_on_nxt = can_on_r;
    if (state_nxt != ST_NORMAL) begin
      can_on_nxt = 1'b0;
    end else if (state_r == ST_NORMAL && host_in.can_medium_control && !cmc_prev_r) begin
      can_on_nxt = 1'b1;
    end else if (!host_in.can_medium_control) begin
      can_on_nxt = 1'b0;
    end
    rst_n_nxt = ~(state_nxt == ST_STARTUP_RST || state_nxt == ST_RESTART_RST
                  || state_nxt == ST_SLEEP || state_nxt == ST_FAILSAFE
                  || state_nxt == ST_FS_DELAY);
    case (state_nxt)
      ST_STARTUP_RST, ST_STARTUP_WAIT: mode_nxt = MODE_STARTUP;
      ST_RESTART_RST, ST_RESTART_WAIT: mode_nxt = MODE_RESTART;
      ST_NORMAL: mode_nxt = MODE_NORMAL;
      ST_FLASH: mode_nxt = MODE_FLASH;
      ST_STANDBY: mode_nxt = MODE_STANDBY;
      ST_SLEEP: mode_nxt = MODE_SLEEP;
      default: mode_nxt = MODE_FAILSAFE;
    endcase
    grant_nxt.can_enable = can_on_nxt;
    grant_nxt.lin_enable = (state_nxt == ST_NORMAL);
    grant_nxt.enable = (state_nxt == ST_NORMAL) && host_in.enable_request;
    v1_nxt = ~(state_nxt == ST_SLEEP || state_nxt == ST_FAILSAFE || state_nxt == ST_FS_DELAY);
    inh_oe_n_nxt = ~(state_nxt == ST_NORMAL);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cmc_prev_r <= 1'b0;
      can_on_r <= 1'b0;
      host_reset_out_n <= 1'b0;
      reset_source_out <= RS_POWER_ON;
      mode_out <= MODE_STARTUP;
      grant_out <= '0;
      mcu_supply_regulator_out <= 1'b1;
      switched_battery_output_out <= 1'b0;
      wake_sample_out <= 1'b0;
      inhibit_limp_output_out <= 1'b0;
      inhibit_limp_output_oe_n_out <= 1'b1;
    end else begin
      cmc_prev_r <= host_in.can_medium_control;
      can_on_r <= can_on_nxt;
      host_reset_out_n <= rst_n_nxt;
      reset_source_out <= rsrc_nxt;
      mode_out <= mode_nxt;
      grant_out <= grant_nxt;
      mcu_supply_regulator_out <= v1_nxt;
      switched_battery_output_out <= v3_r;
      wake_sample_out <= sample_r;
      inhibit_limp_output_out <= host_in.inhibit_level;
      inhibit_limp_output_oe_n_out <= inh_oe_n_nxt;
    end
  end

endmodule // fsmc_top

// File: shared/fsmc_pkg.sv
package fsmc_pkg;

  // =====================================================
  // timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TMR_W = 12;
  localparam int unsigned RST_SHORT_US = 2;
  localparam int unsigned RST_LONG_US = 20;
  localparam int unsigned WD_INIT_US = 30;
  localparam int unsigned RET_US = 10;
  localparam int unsigned INT_RESP_US = 16;
  localparam int unsigned CYC_PERIOD_US = 32;
  localparam int unsigned CYC_ON_US = 1;
  localparam logic [TMR_W-1:0] RST_SHORT_CYC = TMR_W'(RST_SHORT_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] RST_LONG_CYC = TMR_W'(RST_LONG_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] WD_INIT_CYC = TMR_W'(WD_INIT_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] RET_CYC = TMR_W'(RET_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] INT_RESP_CYC = TMR_W'(INT_RESP_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] CYC_PERIOD_CYC = TMR_W'(CYC_PERIOD_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] CYC_ON_CYC = TMR_W'(CYC_ON_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] TMR_IDLE = 12'h000;

  // =====================================================
  // reset source codes
  localparam logic [3:0] RS_POWER_ON = 4'h0;
  localparam logic [3:0] RS_WAKE = 4'h1;
  localparam logic [3:0] RS_WD_SERVICE = 4'h2;
  localparam logic [3:0] RS_WD_INIT = 4'h3;
  localparam logic [3:0] RS_INT_TIMEOUT = 4'h4;
  localparam logic [3:0] RS_SOFT = 4'h5;
  localparam logic [3:0] RS_FLASH_ENTRY = 4'h6;
  localparam logic [3:0] RS_FLASH_EXIT = 4'h7;
  localparam logic [3:0] RS_FAILSAFE_EXIT = 4'h8;

  // =====================================================
  // mode codes on mode_out
  localparam logic [2:0] MODE_STARTUP = 3'h0;
  localparam logic [2:0] MODE_RESTART = 3'h1;
  localparam logic [2:0] MODE_NORMAL = 3'h2;
  localparam logic [2:0] MODE_FLASH = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h4;
  localparam logic [2:0] MODE_SLEEP = 3'h5;
  localparam logic [2:0] MODE_FAILSAFE = 3'h6;

  // =====================================================
  // carriers
  typedef struct packed {
    logic wake_can;
    logic wake_lin;
    logic wake_local;
    logic osc_ok;
    logic v1_ok;
    logic severe_fault;
  } fsmc_pins_type;

  localparam int unsigned PINS_W = 6;
  localparam fsmc_pins_type PINS_RESET = 6'h06;

  typedef struct packed {
    logic wd_init_ok;
    logic wd_service_err;
    logic int_raise;
    logic int_ack;
    logic soft_reset;
    logic flash_select;
    logic flash_entry;
    logic flash_exit;
    logic standby_req;
    logic sleep_req;
    logic normal_req;
    logic reset_length_select;
    logic can_medium_control;
    logic enable_request;
    logic inhibit_level;
    logic wake_cyclic;
    logic v3_on;
  } fsmc_host_type;

  typedef struct packed {
    logic can_enable;
    logic lin_enable;
    logic enable;
  } fsmc_grant_type;

  typedef enum logic [3:0] {
    ST_STARTUP_RST,
    ST_STARTUP_WAIT,
    ST_RESTART_RST,
    ST_RESTART_WAIT,
    ST_NORMAL,
    ST_FLASH,
    ST_STANDBY,
    ST_SLEEP,
    ST_FAILSAFE,
    ST_FS_DELAY
  } fsmc_state_type;

endpackage

// File: verif/fsmc_host_model.sv
module fsmc_host_model
  import fsmc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic host_reset_n_in,
  input wire logic int_raise_in,
  input wire logic init_en_in,
  input wire logic ack_en_in,
  input wire logic slow_in,
  output logic wd_init_ok_out,
  output logic int_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_seen_r;
  int init_cnt_r;
  int ack_cnt_r;

  initial begin
    wd_init_ok_out = 1'b0;
    int_ack_out = 1'b0;
  end

  // ==========
  // host answers; a reset mid-count drops a pending init
  always @(posedge mclk_in) begin
    rst_seen_r <= host_reset_n_in;
    wd_init_ok_out <= 1'b0;
    int_ack_out <= 1'b0;
    if (reset_in || !host_reset_n_in) begin
      init_cnt_r <= 0;
      ack_cnt_r <= 0;
    end else begin
      if (!rst_seen_r && init_en_in) begin
        init_cnt_r <= slow_in ? 3000 : 20;
      end else if (init_cnt_r > 0) begin
        init_cnt_r <= init_cnt_r - 1;
        wd_init_ok_out <= (init_cnt_r == 1);
      end
      if (int_raise_in && ack_en_in) begin
        ack_cnt_r <= 40;
      end else if (ack_cnt_r > 0) begin
        ack_cnt_r <= ack_cnt_r - 1;
        int_ack_out <= (ack_cnt_r == 1);
      end
    end
  end
endmodule // fsmc_host_model

// File: verif/fsmc_properties.sv
module fsmc_properties
  import fsmc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire fsmc_pins_type pins_in,
  input wire fsmc_host_type host_in,
  input wire logic host_reset_out_n,
  input wire logic [3:0] reset_source_out,
  input wire logic [2:0] mode_out,
  input wire fsmc_grant_type grant_out,
  input wire logic mcu_supply_regulator_out,
  input wire logic inhibit_limp_output_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // length of the current host reset
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  always_comb begin
    low_nxt = host_reset_out_n ? 16'h0000 : low_r + 16'h0001;
  end
  always_ff @(posedge mclk_in) begin
    low_r <= reset_in ? 16'h0000 : low_nxt;
  end

  default clocking dcb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // ==========
  // mode checks
  fault_entry_a: assert property (pins_in.severe_fault [*6] |-> mode_out == MODE_FAILSAFE)
    else $error("severe fault did not reach fail-safe");
  failsafe_quiet_a: assert property (mode_out == MODE_FAILSAFE |-> !host_reset_out_n && !mcu_supply_regulator_out)
    else $error("fail-safe left reset or regulator on");
  osc_hold_a: assert property ((mode_out == MODE_FAILSAFE && !pins_in.osc_ok) [*4] |=> mode_out == MODE_FAILSAFE)
    else $error("fail-safe left with bad oscillator");
  startup_low_a: assert property ($changed(mode_out) && mode_out == MODE_STARTUP |-> !host_reset_out_n)
    else $error("start-up entered with reset released");
  reset_len_a: assert property ($rose(host_reset_out_n) |-> low_r >= 16'(RST_SHORT_CYC) - 16'h0002)
    else $error("host reset released too early");
  restart_len_a: assert property ($rose(host_reset_out_n) && mode_out == MODE_RESTART |->
    low_r >= 16'(RST_LONG_CYC) - 16'h0002)
    else $error("restart reset shorter than long length");
  restart_target_a: assert property ($past(mode_out) == MODE_RESTART |-> mode_out != MODE_FLASH)
    else $error("restart led to flash mode");
  outside_normal_a: assert property (mode_out != MODE_NORMAL |->
    inhibit_limp_output_oe_n_out && !grant_out.can_enable)
    else $error("grant outside normal mode");
  can_cmc_a: assert property ($rose(grant_out.can_enable) |->
    $past(host_in.can_medium_control) && mode_out == MODE_NORMAL)
    else $error("can enabled without medium control");
  wd_reset_a: assert property (mode_out == MODE_NORMAL && host_in.wd_service_err |=>
    mode_out == MODE_STARTUP && reset_source_out == RS_WD_SERVICE && !host_reset_out_n)
    else $error("watchdog error gave no reset");

  failsafe_c: cover property (mode_out == MODE_FAILSAFE);
  restart_c: cover property ($rose(host_reset_out_n) && mode_out == MODE_RESTART);
  can_on_c: cover property ($rose(grant_out.can_enable));
endmodule // fsmc_properties

bind fsmc_top fsmc_properties u_props (
  .mclk_in(mclk_in),
  .reset_in(reset_in),
  .pins_in(pins_in),
  .host_in(host_in),
  .host_reset_out_n(host_reset_out_n),
  .reset_source_out(reset_source_out),
  .mode_out(mode_out),
  .grant_out(grant_out),
  .mcu_supply_regulator_out(mcu_supply_regulator_out),
  .inhibit_limp_output_oe_n_out(inhibit_limp_output_oe_n_out)
);

// File: verif/tb_fsmc_top.sv
module tb_fsmc_top
  import fsmc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT = int'(RST_SHORT_CYC);
  localparam int LONG = int'(RST_LONG_CYC);
  localparam int INIT = int'(WD_INIT_CYC);
  localparam int RET = int'(RET_CYC);
  localparam int RESP = int'(INT_RESP_CYC);
  localparam int B_WDERR = 15;
  localparam int B_INT = 14;
  localparam int B_FLASH = 11;
  localparam int B_STBY = 8;
  localparam int B_FENTRY = 10;
  logic mclk_in;
  logic reset_in;
  fsmc_pins_type pins;
  fsmc_host_type tb_host;
  fsmc_host_type host;
  logic m_init, m_ack, init_en, ack_en, slow;
  logic host_reset_out_n;
  logic [3:0] reset_source_out;
  logic [2:0] mode_out;
  fsmc_grant_type grant_out;
  logic reg_on, v3, smp, inh, inh_oe_n;
  int bad_count;
  int comparisons;
  int n;

  always_comb begin
    host = tb_host;
    host.wd_init_ok = m_init;
    host.int_ack = m_ack;
  end

  fsmc_top dut (.mclk_in(mclk_in), .reset_in(reset_in), .pins_in(pins), .host_in(host),
    .host_reset_out_n(host_reset_out_n), .reset_source_out(reset_source_out), .mode_out(mode_out),
    .grant_out(grant_out), .mcu_supply_regulator_out(reg_on), .switched_battery_output_out(v3),
    .wake_sample_out(smp), .inhibit_limp_output_out(inh), .inhibit_limp_output_oe_n_out(inh_oe_n));

  fsmc_host_model u_host (.mclk_in(mclk_in), .reset_in(reset_in), .host_reset_n_in(host_reset_out_n),
    .int_raise_in(host.int_raise), .init_en_in(init_en), .ack_en_in(ack_en), .slow_in(slow),
    .wd_init_ok_out(m_init), .int_ack_out(m_ack));

  // ==========
  // helpers
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_dur(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %0t %s took %0d cycles", $time, what, got);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode_out !== m && n < lim) begin
      tick(1);
      n++;
    end
    chk_val({1'b0, mode_out}, {1'b0, m}, "mode");
  endtask
  // bounded, so a stuck reset cannot hang the run
  task automatic wait_rel(input int lim);
    n = 0;
    while (host_reset_out_n !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic pulse(input int b);
    tb_host[b] <= 1'b1;
    tick(1);
    tb_host[b] <= 1'b0;
  endtask
  task automatic wake(input int b);
    pins[b] <= 1'b1;
    tick(6);
    pins[b] <= 1'b0;
  endtask

  // ==========
  // scenarios
  task automatic sc_power_up();
    chk_val({1'b0, mode_out}, {1'b0, MODE_STARTUP}, "power-up mode");
    chk_val(reset_source_out, RS_POWER_ON, "power-up source");
    chk_val({3'h0, inh_oe_n}, 4'h1, "inhibit floating");
    wait_rel(600);
    chk_dur(n, SHORT - 3, SHORT + 6, "power-up reset");
    wait_mode(MODE_NORMAL, INIT);
  endtask
  task automatic sc_failsafe();
    pins.severe_fault <= 1'b1;
    wait_mode(MODE_FAILSAFE, 10);
    chk_val({2'h0, host_reset_out_n, reg_on}, 4'h0, "fail-safe outputs");
    pins.severe_fault <= 1'b0;
    pins.osc_ok <= 1'b0;
    tick(10);
    wake(5);
    tick(40);
    chk_val({1'b0, mode_out}, {1'b0, MODE_FAILSAFE}, "wake, bad oscillator");
    pins.osc_ok <= 1'b1;
    tick(10);
    wake(5);
    n = 0;
    while (reg_on !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk_dur(n, RET - 10, RET + 6, "restart delay");
    chk_val({1'b0, mode_out}, {1'b0, MODE_STARTUP}, "fail-safe exit");
    chk_val(reset_source_out, RS_FAILSAFE_EXIT, "fail-safe source");
    wait_rel(3000);
    chk_dur(n, LONG - 3, LONG + 6, "fail-safe exit reset");
    wait_mode(MODE_NORMAL, INIT);
  endtask
  task automatic sc_grants();
    chk_val({1'b0, grant_out}, 4'h3, "normal grants");
    chk_val({3'h0, inh_oe_n}, 4'h0, "inhibit driven");
    chk_val({3'h0, inh}, 4'h1, "inhibit level");
    tb_host.can_medium_control <= 1'b1;
    tick(3);
    chk_val({1'b0, grant_out}, 4'h7, "can after medium control");
    tb_host.can_medium_control <= 1'b0;
    tick(3);
  endtask
  task automatic sc_wd_reset();
    pulse(B_WDERR);
    wait_mode(MODE_STARTUP, 5);
    chk_val(reset_source_out, RS_WD_SERVICE, "watchdog source");
    wait_rel(600);
    chk_dur(n, SHORT - 3, SHORT + 6, "default length");
    wait_mode(MODE_NORMAL, INIT);
  endtask
  task automatic sc_interrupt();
    pulse(B_INT);
    tick(RESP + 100);
    chk_val({1'b0, mode_out}, {1'b0, MODE_NORMAL}, "answered interrupt");
    ack_en <= 1'b0;
    tb_host.reset_length_select <= 1'b1;
    pulse(B_INT);
    wait_mode(MODE_STARTUP, RESP + 20);
    chk_dur(n, RESP - 4, RESP + 6, "interrupt timeout");
    chk_val(reset_source_out, RS_INT_TIMEOUT, "interrupt source");
    wait_rel(3000);
    chk_dur(n, LONG - 3, LONG + 6, "selected length");
    ack_en <= 1'b1;
    tb_host.reset_length_select <= 1'b0;
    wait_mode(MODE_NORMAL, INIT);
  endtask
  task automatic sc_restart();
    init_en <= 1'b0;
    pulse(B_FENTRY);
    wait_mode(MODE_STARTUP, 5);
    chk_val(reset_source_out, RS_FLASH_ENTRY, "entry source");
    wait_rel(600);
    wait_mode(MODE_RESTART, INIT + 20);
    chk_dur(n, INIT - 4, INIT + 6, "init window");
    wait_rel(3000);
    chk_dur(n, LONG - 3, LONG + 6, "restart length");
    wait_mode(MODE_FAILSAFE, INIT + 20);
    wake(4);
    wait_mode(MODE_RESTART, RET + LONG + INIT + 100);
    init_en <= 1'b1;
    slow <= 1'b1;
    wait_rel(3000);
    tb_host[B_FLASH] <= 1'b1;
    wait_mode(MODE_NORMAL, INIT);
    pulse(B_FENTRY);
    wait_mode(MODE_FLASH, SHORT + INIT);
    tb_host[B_FLASH] <= 1'b0;
    slow <= 1'b0;
    pulse(9);
    wait_mode(MODE_STARTUP, 5);
    chk_val(reset_source_out, RS_FLASH_EXIT, "exit source");
    wait_mode(MODE_NORMAL, SHORT + INIT);
  endtask
  task automatic sc_standby();
    int hi;
    int cnt;
    hi = 0;
    cnt = 0;
    tb_host.wake_cyclic <= 1'b1;
    pulse(B_STBY);
    wait_mode(MODE_STANDBY, 5);
    repeat (int'(CYC_PERIOD_CYC)) begin
      tick(1);
      hi += (v3 === 1'b1);
      cnt += (smp === 1'b1);
    end
    chk_dur(hi, int'(CYC_ON_CYC) - 1, int'(CYC_ON_CYC) + 1, "cyclic on time");
    chk_dur(cnt, 1, 1, "wake samples");
    tb_host.wake_cyclic <= 1'b0;
    wake(4);
    wait_mode(MODE_STARTUP, 10);
    chk_val(reset_source_out, RS_WAKE, "wake source");
    wait_mode(MODE_NORMAL, SHORT + INIT);
  endtask

  task automatic end_sim();
    $display("counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========
  // clock, main sequence, watchdog
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    reset_in <= 1'b1;
    pins <= 6'h06;
    tb_host <= 17'h0000C;
    init_en <= 1'b1;
    ack_en <= 1'b1;
    slow <= 1'b0;
    tick(8);
    reset_in <= 1'b0;
    tick(1);
    sc_power_up();
    sc_failsafe();
    sc_grants();
    sc_wd_reset();
    sc_interrupt();
    sc_restart();
    sc_standby();
    end_sim();
  end
  initial begin
    #800000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule // tb_fsmc_top
